// >>> flash_protection_decoder.sv
// Overview of operation
// - with the open select set, each range whose disable bit is clear is protected; both disabled means no protection.
// - with the open select clear and both disable bits set, the whole flash array is protected.
// - with the open select clear, each range whose disable bit is clear is unprotected and everything else protected.
// - the high size field selects 2, 4, 8 or 16 Kbytes ending at the top of the map, from 0xF800, 0xF000, 0xE000, 0xC000.
// - the low size field selects a range from 0x4000 ending at 0x43FF, 0x47FF, 0x4FFF or 0x5FFF.
// - after every reset the configuration is fetched from the nonvolatile protection byte in the array.
// - in normal modes software may rewrite the loaded configuration, within the per-field limits.
// - program or erase of a protected address is refused and the violation flag is set.
// - mass erase runs only when the open select and the high disable bit are both set, else violation.
// - the high size field accepts writes only while the high disable bit is set.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module flash_protection_decoder (
	input  wire logic                                    sys_clk,
	input  wire logic                                    reset_n,
	input  wire logic [flash_prot_pkg::REG_ADDR_W-1:0]   reg_addr,
	input  wire logic [flash_prot_pkg::REG_DATA_W-1:0]   reg_wdata,
	input  wire logic                                    reg_write,
	input  wire logic                                    reg_read,
	output logic      [flash_prot_pkg::REG_DATA_W-1:0]   reg_rdata,
	input  wire logic                                    normal_mode,
	output logic                                         nv_read_req,
	input  wire logic                                    nv_read_ack,
	input  wire logic [flash_prot_pkg::CFG_W-1:0]        nv_read_data,
	input  wire logic                                    array_busy,
	input  wire logic                                    array_done,
	output logic                                         array_cmd_valid,
	output logic      [flash_prot_pkg::CMD_W-1:0]        array_cmd_code,
	output logic      [flash_prot_pkg::FLASH_ADDR_W-1:0] array_cmd_addr,
	output logic                                         irq
);
	import flash_prot_pkg::*;

	// ****************************************************
	// state
	// ****************************************************
	logic [CFG_W-1:0]        config_reg;
	logic [ST_W-1:0]         status;
	logic [ST_W-1:0]         irq_mask;
	logic [FLASH_ADDR_W-1:0] target_addr;
	logic                    normal_meta;
	logic                    normal_sync;

	wire                     load_valid;
	wire [CFG_W-1:0]         load_data;
	wire                     loaded;
	wire                     target_protected;

	// ****************************************************
	// configuration fields
	// ****************************************************
	wire       protect_open_select;
	wire       high_range_disable;
	wire [1:0] high_range_size;
	wire       low_range_disable;
	wire [1:0] low_range_size;

	assign protect_open_select = config_reg[CFG_OPEN_BIT];
	assign high_range_disable  = config_reg[CFG_HDIS_BIT];
	assign high_range_size     = config_reg[CFG_HSIZE_LSB +: 2];
	assign low_range_disable   = config_reg[CFG_LDIS_BIT];
	assign low_range_size      = config_reg[CFG_LSIZE_LSB +: 2];

	// ****************************************************
	// submodules
	// ****************************************************
	nv_config_loader u_loader (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.nv_read_ack  (nv_read_ack),
		.nv_read_data (nv_read_data),
		.nv_read_req  (nv_read_req),
		.load_valid   (load_valid),
		.load_data    (load_data),
		.loaded       (loaded)
	);

	protection_range_check u_check (
		.protect_open_select (protect_open_select),
		.high_range_disable  (high_range_disable),
		.high_range_size     (high_range_size),
		.low_range_disable   (low_range_disable),
		.low_range_size      (low_range_size),
		.target_addr         (target_addr),
		.is_protected        (target_protected)
	);

	// ****************************************************
	// register decode
	// ****************************************************
	wire sel_config;
	wire sel_status;
	wire sel_mask;
	wire sel_target;
	wire sel_command;
	wire cfg_write;

	assign sel_config  = (reg_addr == OFF_CONFIG);
	assign sel_status  = (reg_addr == OFF_STATUS);
	assign sel_mask    = (reg_addr == OFF_MASK);
	assign sel_target  = (reg_addr == OFF_TARGET);
	assign sel_command = (reg_addr == OFF_COMMAND);
	// special modes keep the loaded value untouchable
	assign cfg_write   = reg_write && sel_config && normal_sync && loaded;

	// ****************************************************
	// next configuration
	// ****************************************************
	wire [CFG_W-1:0] write_cfg;
	wire [1:0]       next_hsize;
	wire [CFG_W-1:0] next_config;

	// size frozen while the high range is live
	assign next_hsize = high_range_disable ? reg_wdata[CFG_HSIZE_LSB +: 2]
		: high_range_size;
	assign write_cfg  = {reg_wdata[CFG_OPEN_BIT:CFG_HDIS_BIT], next_hsize,
		reg_wdata[CFG_LDIS_BIT:0]};
	assign next_config = load_valid ? load_data
		: cfg_write ? write_cfg : config_reg;

	// ****************************************************
	// command launch and check
	// ****************************************************
	wire [CMD_W-1:0] cmd_code;
	wire             launch;
	wire             cmd_known;
	wire             cmd_mass;
	wire             can_run;
	wire             mass_ok;
	wire             allowed;
	wire             cmd_issue;
	wire             cmd_denied;
	wire             cmd_error;

	assign cmd_code   = reg_wdata[CMD_W-1:0];
	assign launch     = reg_write && sel_command;
	assign cmd_known  = (cmd_code == CMD_PROGRAM) || (cmd_code == CMD_SECTOR_ERASE)
		|| cmd_mass;
	assign cmd_mass   = (cmd_code == CMD_MASS_ERASE);
	// nothing runs before the stored byte arrives
	assign can_run    = loaded && !array_busy && !array_cmd_valid;
	assign mass_ok    = protect_open_select && high_range_disable;
	assign allowed    = cmd_mass ? mass_ok : !target_protected;
	assign cmd_issue  = launch && cmd_known && can_run && allowed;
	assign cmd_denied = launch && cmd_known && can_run && !allowed;
	assign cmd_error  = launch && !(cmd_known && can_run);

	// ****************************************************
	// status and interrupt
	// ****************************************************
	wire [ST_W-1:0] status_set;
	wire [ST_W-1:0] status_clr;
	wire [ST_W-1:0] next_status;
	wire            next_irq;

	assign status_set  = {cmd_error, array_done, cmd_denied};
	assign status_clr  = (reg_write && sel_status) ? reg_wdata[ST_W-1:0] : {ST_W{1'b0}};
	// a new event beats a same-cycle clear
	assign next_status = (status & ~status_clr) | status_set;
	assign next_irq    = |(status & irq_mask);

	// ****************************************************
	// read mux
	// ****************************************************
	wire [REG_DATA_W-1:0] read_mux;

	assign read_mux = sel_config  ? {{(REG_DATA_W-CFG_W){1'b0}}, config_reg}
		: sel_status  ? {{(REG_DATA_W-ST_W){1'b0}}, status}
		: sel_mask    ? {{(REG_DATA_W-ST_W){1'b0}}, irq_mask}
		: sel_target  ? target_addr
		: sel_command ? {14'h0000, array_busy, loaded}
		: {REG_DATA_W{1'b0}};

	// ****************************************************
	// flops
	// ****************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			normal_meta <= 1'b0;
			normal_sync <= 1'b0;
		end else begin
			normal_meta <= normal_mode;
			normal_sync <= normal_meta;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			config_reg  <= CFG_RESET;
			status      <= ST_RESET;
			irq_mask    <= MASK_RESET;
			target_addr <= 16'h0000;
			irq         <= 1'b0;
		end else begin
			config_reg  <= next_config;
			status      <= next_status;
			irq         <= next_irq;
			if (reg_write && sel_mask) begin
				irq_mask <= reg_wdata[ST_W-1:0];
			end
			if (reg_write && sel_target) begin
				target_addr <= reg_wdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			array_cmd_valid <= 1'b0;
			array_cmd_code  <= 8'h00;
			array_cmd_addr  <= 16'h0000;
			reg_rdata       <= 16'h0000;
		end else begin
			array_cmd_valid <= cmd_issue;
			if (cmd_issue) begin
				array_cmd_code <= cmd_code;
				array_cmd_addr <= target_addr;
			end
			reg_rdata <= reg_read ? read_mux : 16'h0000;
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence seq_denied_launch;
		launch && cmd_known && can_run && !allowed;
	endsequence

	sequence seq_allowed_launch;
		launch && cmd_known && can_run && allowed;
	endsequence

	sequence seq_mass_closed;
		launch && cmd_mass && can_run && !(protect_open_select && high_range_disable);
	endsequence

	AST_NONE_OPEN: assert property (
		(protect_open_select && high_range_disable && low_range_disable) |-> !target_protected)
		else $error("open select with both ranges disabled still protects");

	AST_FULL_CLOSED: assert property (
		(!protect_open_select && high_range_disable && low_range_disable) |-> target_protected)
		else $error("closed select with both ranges disabled leaves a hole");

	AST_HOLE_CLOSED: assert property (
		(!protect_open_select && !high_range_disable && target_addr == 16'hFFFF)
		|-> !target_protected)
		else $error("enabled high range not unprotected in closed mode");

	AST_HIGH_EDGE: assert property (
		(protect_open_select && !high_range_disable && low_range_disable
		&& high_range_size == 2'h0)
		|-> (target_protected == (target_addr >= 16'hF800)))
		else $error("smallest high range boundary wrong");

	AST_LOW_EDGE: assert property (
		(protect_open_select && high_range_disable && !low_range_disable
		&& low_range_size == 2'h3)
		|-> (target_protected == (target_addr >= 16'h4000 && target_addr <= 16'h5FFF)))
		else $error("largest low range boundary wrong");

	AST_LOAD_TAKEN: assert property (
		load_valid |=> (config_reg == $past(load_data)))
		else $error("stored byte not loaded into configuration");

	AST_RUNTIME_WRITE: assert property (
		(cfg_write && !load_valid) |=> (protect_open_select == $past(reg_wdata[CFG_OPEN_BIT])
		&& low_range_size == $past(reg_wdata[1:0])))
		else $error("software write did not reach configuration");

	AST_VIOLATION: assert property (
		seq_denied_launch |=> (status[ST_VIOL_BIT] && !array_cmd_valid))
		else $error("protected access not refused with violation flag");

	AST_MASS_GUARD: assert property (
		seq_mass_closed |=> (!array_cmd_valid ##0 status[ST_VIOL_BIT]))
		else $error("mass erase ran while protection enabled");

	AST_HSIZE_LOCK: assert property (
		(cfg_write && !high_range_disable && !load_valid)
		|=> (high_range_size == $past(high_range_size)))
		else $error("high size changed while high range enabled");

	AST_ISSUE: assert property (
		seq_allowed_launch |=> (array_cmd_valid && array_cmd_addr == $past(target_addr))
		##1 !array_cmd_valid)
		else $error("allowed command not issued once with its address");

	AST_IRQ: assert property (
		(|(status & irq_mask)) |=> irq)
		else $error("unmasked status did not raise interrupt");

	// ****************************************************
	// refusal, hold and boundary checks
	// ****************************************************
	// a refused launch must leave a trace, or software cannot tell a drop from a run
	sequence seq_refused_launch;
		launch && !(cmd_known && can_run);
	endsequence

	AST_REFUSED: assert property (
		seq_refused_launch |=> (status[ST_ERR_BIT] && !array_cmd_valid))
		else $error("refused command reached the array or left no error");

	AST_MASS_OPEN: assert property (
		(launch && cmd_mass && can_run && protect_open_select && high_range_disable)
		|=> array_cmd_valid)
		else $error("mass erase refused with protection fully off");

	AST_HIGH_WIDE: assert property (
		(protect_open_select && !high_range_disable && low_range_disable
		&& high_range_size == 2'h3)
		|-> (target_protected == (target_addr >= 16'hC000)))
		else $error("largest high range boundary wrong");

	AST_LOW_NARROW: assert property (
		(protect_open_select && high_range_disable && !low_range_disable
		&& low_range_size == 2'h0)
		|-> (target_protected == (target_addr >= 16'h4000 && target_addr <= 16'h43FF)))
		else $error("smallest low range boundary wrong");

	AST_UNLOADED_LOCK: assert property (
		!loaded |-> (config_reg == CFG_RESET))
		else $error("configuration moved before the stored byte arrived");

	AST_CONFIG_HOLD: assert property (
		(!cfg_write && !load_valid) |=> $stable(config_reg))
		else $error("configuration changed without a write or load");

	AST_NO_EARLY_RUN: assert property (
		!loaded |=> !array_cmd_valid)
		else $error("command issued before the stored byte arrived");

	// zero outside the answer cycle, so a late sample shows up at once
	AST_READ_IDLE: assert property (
		!reg_read |=> (reg_rdata == 16'h0000))
		else $error("read data not zero outside the read answer");

	AST_CMD_HELD: assert property (
		!cmd_issue |=> ($stable(array_cmd_code) && $stable(array_cmd_addr)))
		else $error("command code or address moved without an issue");

endmodule : flash_protection_decoder

// >>> flash_prot_pkg.sv
package flash_prot_pkg;

	// ****************************************************
	// bus geometry
	// ****************************************************
	localparam int REG_ADDR_W  = 4;
	localparam int REG_DATA_W  = 16;
	localparam int FLASH_ADDR_W = 16;
	localparam int CFG_W       = 8;
	localparam int CMD_W       = 8;

	// ****************************************************
	// register offsets
	// ****************************************************
	localparam logic [3:0] OFF_CONFIG  = 4'h0;
	localparam logic [3:0] OFF_STATUS  = 4'h1;
	localparam logic [3:0] OFF_MASK    = 4'h2;
	localparam logic [3:0] OFF_TARGET  = 4'h3;
	localparam logic [3:0] OFF_COMMAND = 4'h4;

	// ****************************************************
	// protection_config_register fields
	// ****************************************************
	localparam int CFG_OPEN_BIT  = 7;
	localparam int CFG_NV_BIT    = 6;
	localparam int CFG_HDIS_BIT  = 5;
	localparam int CFG_HSIZE_LSB = 3;
	localparam int CFG_LDIS_BIT  = 2;
	localparam int CFG_LSIZE_LSB = 0;
	// closed, both ranges disabled: whole array protected until loaded
	localparam logic [7:0] CFG_RESET = 8'h24;

	// ****************************************************
	// flash_status_register fields
	// ****************************************************
	localparam int ST_W         = 3;
	localparam int ST_VIOL_BIT  = 0;
	localparam int ST_DONE_BIT  = 1;
	localparam int ST_ERR_BIT   = 2;
	localparam logic [2:0] ST_RESET   = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// ****************************************************
	// command codes
	// ****************************************************
	localparam logic [7:0] CMD_PROGRAM      = 8'h20;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
	localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;

	// ****************************************************
	// range bases
	// ****************************************************
	localparam logic [15:0] HIGH_BASE_0 = 16'hF800;
	localparam logic [15:0] HIGH_BASE_1 = 16'hF000;
	localparam logic [15:0] HIGH_BASE_2 = 16'hE000;
	localparam logic [15:0] HIGH_BASE_3 = 16'hC000;
	localparam logic [15:0] LOW_BASE    = 16'h4000;
	localparam logic [15:0] LOW_END_0   = 16'h43FF;
	localparam logic [15:0] LOW_END_1   = 16'h47FF;
	localparam logic [15:0] LOW_END_2   = 16'h4FFF;
	localparam logic [15:0] LOW_END_3   = 16'h5FFF;

	typedef enum {LOAD_REQ, LOAD_WAIT, LOAD_DONE} load_state_type;

endpackage : flash_prot_pkg

// >>> nv_config_loader.sv
`timescale 1ns/1ps
module nv_config_loader (
	input  wire logic                               sys_clk,
	input  wire logic                               reset_n,
	input  wire logic                               nv_read_ack,
	input  wire logic [flash_prot_pkg::CFG_W-1:0]  nv_read_data,
	output logic                                    nv_read_req,
	output logic                                    load_valid,
	output logic [flash_prot_pkg::CFG_W-1:0]       load_data,
	output logic                                    loaded
);
	import flash_prot_pkg::*;

	load_state_type state;
	load_state_type next_state;
	wire            take_byte;

	assign take_byte = (state == LOAD_WAIT) && nv_read_ack;

	always_comb begin
		case (state)
			LOAD_REQ:  next_state = LOAD_WAIT;
			LOAD_WAIT: next_state = nv_read_ack ? LOAD_DONE : LOAD_WAIT;
			LOAD_DONE: next_state = LOAD_DONE;
			default:   next_state = LOAD_REQ;
		endcase
	end

	// one fetch per reset, never repeated
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= LOAD_REQ;
			nv_read_req <= 1'b0;
			load_valid  <= 1'b0;
			load_data   <= CFG_RESET;
			loaded      <= 1'b0;
		end else begin
			state       <= next_state;
			nv_read_req <= (next_state == LOAD_WAIT);
			load_valid  <= take_byte;
			if (take_byte) begin
				load_data <= nv_read_data;
			end
			loaded      <= loaded | take_byte;
		end
	end

endmodule : nv_config_loader

// >>> protection_range_check.sv
`timescale 1ns/1ps
module protection_range_check (
	input  wire logic                                    protect_open_select,
	input  wire logic                                    high_range_disable,
	input  wire logic [1:0]                              high_range_size,
	input  wire logic                                    low_range_disable,
	input  wire logic [1:0]                              low_range_size,
	input  wire logic [flash_prot_pkg::FLASH_ADDR_W-1:0] target_addr,
	output logic                                         is_protected
);
	import flash_prot_pkg::*;

	function automatic logic in_high(input logic [15:0] a, input logic [1:0] sz);
		case (sz)
			2'h0:    in_high = (a >= HIGH_BASE_0);
			2'h1:    in_high = (a >= HIGH_BASE_1);
			2'h2:    in_high = (a >= HIGH_BASE_2);
			default: in_high = (a >= HIGH_BASE_3);
		endcase
	endfunction : in_high

	function automatic logic in_low(input logic [15:0] a, input logic [1:0] sz);
		logic [15:0] top;
		case (sz)
			2'h0:    top = LOW_END_0;
			2'h1:    top = LOW_END_1;
			2'h2:    top = LOW_END_2;
			default: top = LOW_END_3;
		endcase
		in_low = (a >= LOW_BASE) && (a <= top);
	endfunction : in_low

	wire hit_high;
	wire hit_low;
	wire full_lock;

	assign hit_high  = !high_range_disable && in_high(target_addr, high_range_size);
	assign hit_low   = !low_range_disable && in_low(target_addr, low_range_size);
	assign full_lock = !protect_open_select && high_range_disable && low_range_disable;
	// open: enabled ranges are locked; closed: enabled ranges are the only holes
	assign is_protected = full_lock ? 1'b1
		: protect_open_select ? (hit_high | hit_low)
		: !(hit_high | hit_low);

endmodule : protection_range_check

// >>> flash_protection_decoder_test.sv
`timescale 1ns/1ps
module flash_protection_decoder_test;
	import flash_prot_pkg::*;

	// ****************************************************
	// signals and bookkeeping
	// ****************************************************
	logic                    sys_clk;
	logic                    reset_n;
	logic [REG_ADDR_W-1:0]   reg_addr;
	logic [REG_DATA_W-1:0]   reg_wdata;
	logic                    reg_write;
	logic                    reg_read;
	logic [REG_DATA_W-1:0]   reg_rdata;
	logic                    normal_mode;
	logic                    nv_read_req;
	logic                    nv_read_ack;
	logic [CFG_W-1:0]        nv_read_data;
	logic                    array_busy;
	logic                    array_done;
	logic                    array_cmd_valid;
	logic [CMD_W-1:0]        array_cmd_code;
	logic [FLASH_ADDR_W-1:0] array_cmd_addr;
	logic                    irq;
	int                      num_errors = 0;
	int                      compares = 0;
	// every range boundary of every size code
	localparam logic [15:0] ADDRS [19] = '{16'h3FFF, 16'h4000, 16'h43FF, 16'h4400, 16'h47FF,
		16'h4800, 16'h4FFF, 16'h5000, 16'h5FFF, 16'h6000, 16'hBFFF, 16'hC000, 16'hDFFF,
		16'hE000, 16'hEFFF, 16'hF000, 16'hF7FF, 16'hF800, 16'hFFFF};

`define CHECK(what, exp, got) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("Error %s expected %h seen %h", what, exp, got); \
	end \
end

	flash_protection_decoder u_dut (
		.sys_clk         (sys_clk),
		.reset_n         (reset_n),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_write       (reg_write),
		.reg_read        (reg_read),
		.reg_rdata       (reg_rdata),
		.normal_mode     (normal_mode),
		.nv_read_req     (nv_read_req),
		.nv_read_ack     (nv_read_ack),
		.nv_read_data    (nv_read_data),
		.array_busy      (array_busy),
		.array_done      (array_done),
		.array_cmd_valid (array_cmd_valid),
		.array_cmd_code  (array_cmd_code),
		.array_cmd_addr  (array_cmd_addr),
		.irq             (irq)
	);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ****************************************************
	// bus tasks and expectation
	// ****************************************************
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_rd

	task automatic rd_check(input string what, input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		reg_rd(a, d);
		`CHECK(what, exp, d)
	endtask : rd_check

	function automatic logic exp_prot(input logic [7:0] c, input logic [15:0] a);
		logic [15:0] hb;
		logic [15:0] le;
		logic        inr;
		case (c[4:3])
			2'b00: hb = 16'hF800;
			2'b01: hb = 16'hF000;
			2'b10: hb = 16'hE000;
			default: hb = 16'hC000;
		endcase
		case (c[1:0])
			2'b00: le = 16'h43FF;
			2'b01: le = 16'h47FF;
			2'b10: le = 16'h4FFF;
			default: le = 16'h5FFF;
		endcase
		inr = (!c[5] && a >= hb) || (!c[2] && a >= 16'h4000 && a <= le);
		return c[7] ? inr : !inr;
	endfunction : exp_prot

	// size bits only stick while the high disable is set, so go through that first
	task automatic set_cfg(input logic [7:0] v);
		reg_wr(OFF_CONFIG, {8'h00, v | 8'h20});
		reg_wr(OFF_CONFIG, {8'h00, v});
		rd_check("config", OFF_CONFIG, {8'h00, v});
	endtask : set_cfg

	task automatic do_cmd(input logic [7:0] code, input logic [15:0] addr, input logic ok,
		input logic [15:0] exp_st);
		int          n;
		n = 0;
		reg_wr(OFF_TARGET, addr);
		reg_wr(OFF_COMMAND, {8'h00, code});
		repeat (3) begin
			#1;
			if (array_cmd_valid === 1'b1) n++;
			@(posedge sys_clk);
		end
		`CHECK("cmd issued", ok, 1'(n == 1))
		if (ok) begin
			`CHECK("cmd addr", addr, array_cmd_addr)
			`CHECK("cmd code", code, array_cmd_code)
		end
		rd_check("status", OFF_STATUS, exp_st);
		reg_wr(OFF_STATUS, 16'h0007);
	endtask : do_cmd

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic test_load();
		rd_check("config before load", OFF_CONFIG, 16'h0024);
		for (int i = 0; i < 20 && nv_read_req !== 1'b1; i++) @(posedge sys_clk);
		`CHECK("load request", 1'b1, nv_read_req)
		@(posedge sys_clk);
		nv_read_ack  <= 1'b1;
		nv_read_data <= 8'hBD;
		@(posedge sys_clk);
		nv_read_ack  <= 1'b0;
		nv_read_data <= 8'h42;
		repeat (3) @(posedge sys_clk);
		rd_check("config after load", OFF_CONFIG, 16'h00BD);
		rd_check("loaded", OFF_COMMAND, 16'h0001);
	endtask : test_load

	task automatic test_ranges();
		logic [7:0] c;
		for (int v = 0; v < 128; v++) begin
			c = {v[6], 1'b0, v[5:0]};
			set_cfg(c);
			for (int i = 0; i < 19; i++)
				do_cmd(i[0] ? CMD_PROGRAM : CMD_SECTOR_ERASE, ADDRS[i], !exp_prot(c, ADDRS[i]),
					{15'h0000, exp_prot(c, ADDRS[i])});
		end
	endtask : test_ranges

	task automatic test_mass();
		logic ok;
		for (int v = 0; v < 4; v++) begin
			ok = v[1] & v[0];
			set_cfg({v[1], 1'b0, v[0], 5'b00000});
			do_cmd(CMD_MASS_ERASE, 16'h4000, ok, {15'h0000, !ok});
		end
	endtask : test_mass

	task automatic test_size_lock();
		set_cfg(8'hBD);
		reg_wr(OFF_CONFIG, 16'h0085);
		reg_wr(OFF_CONFIG, 16'h009D);
		rd_check("locked size", OFF_CONFIG, 16'h0085);
	endtask : test_size_lock

	task automatic test_mode();
		@(posedge sys_clk);
		normal_mode <= 1'b0;
		repeat (4) @(posedge sys_clk);
		reg_wr(OFF_CONFIG, 16'h0000);
		rd_check("config outside normal", OFF_CONFIG, 16'h0085);
		@(posedge sys_clk);
		normal_mode <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask : test_mode

	task automatic test_irq_busy();
		set_cfg(8'h24);
		reg_wr(OFF_TARGET, 16'h8000);
		reg_wr(OFF_COMMAND, {8'h00, CMD_PROGRAM});
		repeat (3) @(posedge sys_clk);
		`CHECK("irq masked", 1'b0, irq)
		reg_wr(OFF_MASK, 16'h0001);
		repeat (2) @(posedge sys_clk);
		`CHECK("irq raised", 1'b1, irq)
		reg_wr(OFF_STATUS, 16'h0001);
		repeat (2) @(posedge sys_clk);
		`CHECK("irq cleared", 1'b0, irq)
		array_done <= 1'b1;
		@(posedge sys_clk);
		array_done <= 1'b0;
		rd_check("done bit", OFF_STATUS, 16'h0002);
		reg_wr(OFF_STATUS, 16'h0007);
		set_cfg(8'hA4);
		@(posedge sys_clk);
		array_busy <= 1'b1;
		rd_check("busy view", OFF_COMMAND, 16'h0003);
		do_cmd(CMD_PROGRAM, 16'h8000, 1'b0, 16'h0004);
		array_busy <= 1'b0;
		do_cmd(CMD_PROGRAM, 16'h8000, 1'b1, 16'h0000);
		rd_check("unmapped", 4'h7, 16'h0000);
	endtask : test_irq_busy

	// stored byte sits in the top sector: refused while locked, taken once opened
	task automatic test_nv_byte();
		set_cfg(8'h24);
		do_cmd(CMD_PROGRAM, 16'hFF0D, 1'b0, 16'h0001);
		set_cfg(8'h00);
		do_cmd(CMD_PROGRAM, 16'hFF0D, 1'b1, 16'h0000);
		do_cmd(8'h00, 16'hFF0D, 1'b0, 16'h0004);
	endtask : test_nv_byte

	// ****************************************************
	// run control
	// ****************************************************
	task automatic complete_run();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	initial begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end

	initial begin
		reset_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		normal_mode = 1'b1;
		nv_read_ack = 1'b0;
		nv_read_data = 8'h00;
		array_busy = 1'b0;
		array_done = 1'b0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		test_load();
		test_ranges();
		test_mass();
		test_size_lock();
		test_mode();
		test_irq_busy();
		test_nv_byte();
		complete_run();
	end

endmodule : flash_protection_decoder_test
